// ===== include/prot_pkg.sv
// Purpose: shared constants and carriers for the protection and restart sequencer
// Assumes: 100 MHz clock; analog thresholds arrive as comparator levels
// Notes: times are kept in their own unit and converted to cycles here
package prot_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int BLANK_TIME_MS = 20;
  localparam int BURST_ENTRY_TIME_MS = 20;
  localparam int SPIKE_BLANK_TIME_US = 30;
  localparam int BLANK_CYCLES = BLANK_TIME_MS * 1000 * CLK_MHZ;
  localparam int BURST_CYCLES = BURST_ENTRY_TIME_MS * 1000 * CLK_MHZ;
  localparam int SPIKE_CYCLES = SPIKE_BLANK_TIME_US * CLK_MHZ;
  localparam int EXT_COUNT_FULL = 256;
  localparam int TIMER_W = 32;
  localparam int EXT_W = 9;

  // ****************************************
  // restart modes and parity
  // ****************************************
  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_NORMAL_RESTART = 2'h1,
    MODE_ODD_SKIP = 2'h3,
    MODE_NON_SWITCH = 2'h2
  } restart_mode_t;
  localparam logic PARITY_ODD = 1'h1;
  localparam logic PARITY_EVEN = 1'h0;

  // comparator outputs from the analog front end
  typedef struct packed {
    logic fb_above_4v0;
    logic fb_above_4v5;
    logic fb_above_3v5;
    logic fb_below_3v2;
    logic fb_below_burst_entry;
    logic vcc_above_17v;
    logic vcc_below_10v5;
    logic vcc_above_20v5;
    logic vcc_above_25v5;
    logic temp_above_130c;
    logic temp_below_recover;
    logic mfp_below_0v4;
    logic mfp_below_0v9;
    logic mfp_above_4v5;
  } comparators_t;

  // controls back to the power stage
  typedef struct packed {
    logic gate_enable;
    logic softstart_active;
    logic full_current_limit;
    logic burst_limit_select;
    logic internal_bias_on;
    logic startup_cell_on;
    logic charge_switch;
    logic discharge_switch;
  } stage_ctrl_t;
endpackage : prot_pkg

// ===== src/ext_blank_counter.sv
// Purpose: extended blanking counter working the multi-function pin
// Assumes: pin comparators are synchronous to clk_in
// Notes: discharge to 0.9V, charge to 4.5V, one count per charge
`timescale 1ns/1ps
`default_nettype none
module ext_blank_counter #(
  parameter int COUNT_FULL = prot_pkg::EXT_COUNT_FULL
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // control and pin comparators
  input wire logic run_in,
  input wire logic pin_below_0v9_in,
  input wire logic pin_above_4v5_in,
  // results
  output logic charge_switch_out,
  output logic discharge_switch_out,
  output logic done_out
);
  typedef struct packed {
    logic charging;
    logic discharging;
    logic done;
    logic [prot_pkg::EXT_W-1:0] count;
  } ext_state_t;

  ext_state_t state_reg;
  ext_state_t state_next;

  // ****************************************
  // charge and discharge sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    if (!run_in) begin
      state_next = '0;
    end else if (!state_reg.done) begin
      if (!state_reg.charging && !state_reg.discharging) begin
        state_next.discharging = 1'h1; // see R13
      end else if (state_reg.discharging && pin_below_0v9_in) begin
        state_next.discharging = 1'h0; // see R13
        state_next.charging = 1'h1;
      end else if (state_reg.charging && pin_above_4v5_in) begin
        state_next.count = state_reg.count + 9'h001; // see R13
        state_next.charging = 1'h0;
        if (state_reg.count == 9'(COUNT_FULL - 1)) begin
          state_next.done = 1'h1; // see R14
        end else begin
          state_next.discharging = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign charge_switch_out = state_reg.charging;
  assign discharge_switch_out = state_reg.discharging;
  assign done_out = state_reg.done;
endmodule : ext_blank_counter
`default_nettype wire

// ===== src/smps_protection_restart_ctrl.sv
// Purpose: protection, burst and restart sequencing of the switching controller
// Assumes: comparator levels synchronous to clk_in; lockout edges frame restart cycles
// Notes: long timers are parameters so a simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: feedback above 4.0V leaves burst, full limit
// R2: odd-skip odd cycles: no faults, no pulses
// R3: odd-skip even cycles: check, soft start, exit
// R4: non-switch even cycles: check only, no pulses
// R5: faults map onto their restart mode
// R6: softstart overvoltage: 20.5V and 4.5V feedback
// R7: global overvoltage above 25.5V always trips; code checks it only while powered in run mode or an even cycle
// R8: over-temperature non-switch, recover after hysteresis
// R9: pin below 0.4V forces non-switch, gate off
// R10: supply lockout below 10.5V, restart at 17V
// R11: shorted optocoupler handled by lockout path
// R12: feedback above 4.5V starts 20ms blanking
// R13: extended counter discharges, charges, counts per charge
// R14: count 256 plus overload, 30us, odd-skip
// R15: total blanking is built-in plus extended
// R16: burst entry after 20ms below threshold
// R17: burst bias on 3.5V, off 3.2V, reduced limit
// R18: parity toggles per lockout-on, odd on entry
module smps_protection_restart_ctrl #(
  parameter int BLANK_CYCLES = prot_pkg::BLANK_CYCLES,
  parameter int BURST_CYCLES = prot_pkg::BURST_CYCLES,
  parameter int SPIKE_CYCLES = prot_pkg::SPIKE_CYCLES,
  parameter int EXT_COUNT_FULL = prot_pkg::EXT_COUNT_FULL
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // comparator levels
  input wire prot_pkg::comparators_t cmp_in,
  // soft start finished, from the soft start generator
  input wire logic softstart_done_in,
  // power stage controls
  output prot_pkg::stage_ctrl_t ctrl_out,
  // status
  output prot_pkg::restart_mode_t mode_out,
  output logic parity_odd_out,
  output logic burst_active_out
);
  typedef struct packed {
    prot_pkg::restart_mode_t mode;
    logic parity;
    logic powered;
    logic softstart;
    logic burst;
    logic burst_bias;
    logic ext_run;
    logic [prot_pkg::TIMER_W-1:0] blank_cnt;
    logic [prot_pkg::TIMER_W-1:0] burst_cnt;
    logic [prot_pkg::TIMER_W-1:0] spike_cnt;
    prot_pkg::stage_ctrl_t ctrl;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;
  logic ext_charge;
  logic ext_discharge;
  logic ext_done;
  logic lockout_on;
  logic lockout_off;
  logic odd_fault;
  logic nonsw_fault;
  logic fault_check;
  logic overload_trip;
  logic temp_hold;

  // ****************************************
  // extended blanking counter
  // ****************************************
  ext_blank_counter #(
    .COUNT_FULL(EXT_COUNT_FULL)
  ) u_ext_blank (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .run_in(state_reg.ext_run),
    .pin_below_0v9_in(cmp_in.mfp_below_0v9),
    .pin_above_4v5_in(cmp_in.mfp_above_4v5),
    .charge_switch_out(ext_charge),
    .discharge_switch_out(ext_discharge),
    .done_out(ext_done)
  );

  // ****************************************
  // fault classification
  // ****************************************
  // lockout edges mark the start and end of each restart cycle
  assign lockout_on = !state_reg.powered && cmp_in.vcc_above_17v; // see R10
  assign lockout_off = state_reg.powered && cmp_in.vcc_below_10v5; // see R10 R11
  // spike counter saturated means overload outlasted both blanking stages
  assign overload_trip = (state_reg.spike_cnt >= 32'(SPIKE_CYCLES)) && cmp_in.fb_above_4v5; // see R14 R15
  assign odd_fault = cmp_in.vcc_above_25v5 // see R7
    || (state_reg.softstart && cmp_in.vcc_above_20v5 && cmp_in.fb_above_4v5) // see R6
    || overload_trip; // see R5
  // thermal fault holds until the lower recovery threshold is passed
  assign temp_hold = cmp_in.temp_above_130c || (state_reg.mode == prot_pkg::MODE_NON_SWITCH && !cmp_in.temp_below_recover);
  assign nonsw_fault = temp_hold || cmp_in.mfp_below_0v4; // see R8 R9 R5
  // faults are looked at while running or in an even restart cycle
  assign fault_check = (state_reg.mode == prot_pkg::MODE_RUN) || (state_reg.parity == prot_pkg::PARITY_EVEN); // see R2 R18

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    // supply lockout framing, recharge restarts a cycle
    if (lockout_on) begin
      state_next.powered = 1'h1;
      state_next.softstart = 1'h1;
      state_next.parity = ~state_reg.parity; // see R18
    end else if (lockout_off) begin
      state_next.powered = 1'h0; // see R10
      state_next.softstart = 1'h0;
      if (state_reg.mode == prot_pkg::MODE_RUN) begin
        state_next.mode = prot_pkg::MODE_NORMAL_RESTART; // see R5 R11
      end
    end else if (softstart_done_in) begin
      state_next.softstart = 1'h0;
    end
    // end of a restart cycle at an even cycle without a fault
    if (lockout_on && state_reg.mode != prot_pkg::MODE_RUN && state_reg.parity == prot_pkg::PARITY_ODD) begin
      if (!odd_fault && !nonsw_fault) begin
        state_next.mode = prot_pkg::MODE_RUN; // see R3 R4
      end
    end
    if (state_reg.mode == prot_pkg::MODE_NORMAL_RESTART && lockout_on) begin
      state_next.mode = prot_pkg::MODE_RUN; // see R10
    end
    // fault entry; non-switch wins over odd-skip
    if (fault_check && state_reg.powered && !lockout_off) begin
      if (nonsw_fault) begin
        state_next.mode = prot_pkg::MODE_NON_SWITCH; // see R8 R9
      end else if (odd_fault) begin
        state_next.mode = prot_pkg::MODE_ODD_SKIP; // see R6 R7 R14
      end
      // the rail stays up until it sags to lockout-off; dropping powered here would
      // fake a lockout-on at once while the supply is still above 17V
      if ((nonsw_fault || odd_fault) && state_reg.mode == prot_pkg::MODE_RUN) begin
        state_next.parity = prot_pkg::PARITY_ODD; // see R18
      end
    end
    // built-in blanking then extended counter
    if (cmp_in.fb_above_4v5 && state_reg.mode == prot_pkg::MODE_RUN) begin
      if (state_reg.blank_cnt < 32'(BLANK_CYCLES)) begin
        state_next.blank_cnt = state_reg.blank_cnt + 32'h1; // see R12
      end
    end else begin
      state_next.blank_cnt = '0;
    end
    state_next.ext_run = (state_reg.blank_cnt >= 32'(BLANK_CYCLES)) && cmp_in.fb_above_4v5; // see R12 R15
    if (ext_done && cmp_in.fb_above_4v5) begin
      if (state_reg.spike_cnt < 32'(SPIKE_CYCLES)) begin
        state_next.spike_cnt = state_reg.spike_cnt + 32'h1; // see R14
      end
    end else begin
      state_next.spike_cnt = '0;
    end
    // burst entry timer, cleared in normal operation
    if (!state_reg.burst && cmp_in.fb_below_burst_entry && state_reg.mode == prot_pkg::MODE_RUN) begin
      state_next.burst_cnt = state_reg.burst_cnt + 32'h1; // see R16
      if (state_reg.burst_cnt >= 32'(BURST_CYCLES - 1)) begin
        state_next.burst = 1'h1;
        state_next.burst_bias = 1'h0;
      end
    end else begin
      state_next.burst_cnt = '0; // see R16
    end
    if (state_reg.burst) begin
      if (cmp_in.fb_above_4v0 || state_next.mode != prot_pkg::MODE_RUN) begin
        state_next.burst = 1'h0; // see R1
        state_next.burst_bias = 1'h0;
      end else if (cmp_in.fb_above_3v5) begin
        state_next.burst_bias = 1'h1; // see R17
      end else if (cmp_in.fb_below_3v2) begin
        state_next.burst_bias = 1'h0; // see R17
      end
    end
    // stage controls registered from the next state
    state_next.ctrl.startup_cell_on = !state_next.powered; // see R10
    state_next.ctrl.softstart_active = state_next.softstart;
    state_next.ctrl.full_current_limit = !state_next.burst; // see R1
    state_next.ctrl.burst_limit_select = state_next.burst; // see R17
    state_next.ctrl.internal_bias_on = state_next.powered && (!state_next.burst || state_next.burst_bias);
    state_next.ctrl.charge_switch = ext_charge; // see R13
    state_next.ctrl.discharge_switch = ext_discharge; // see R13
    unique case (state_next.mode)
      prot_pkg::MODE_RUN: begin
        state_next.ctrl.gate_enable = state_next.powered && (!state_next.burst || state_next.burst_bias);
      end
      prot_pkg::MODE_NORMAL_RESTART: begin
        state_next.ctrl.gate_enable = 1'h0;
      end
      prot_pkg::MODE_ODD_SKIP: begin
        // only even cycles may try a soft start
        state_next.ctrl.gate_enable = state_next.powered && state_next.parity == prot_pkg::PARITY_EVEN; // see R2 R3
      end
      prot_pkg::MODE_NON_SWITCH: begin
        state_next.ctrl.gate_enable = 1'h0; // see R4 R9
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ctrl_out = state_reg.ctrl;
  assign mode_out = state_reg.mode;
  assign parity_odd_out = state_reg.parity;
  assign burst_active_out = state_reg.burst;
endmodule : smps_protection_restart_ctrl
`default_nettype wire

// ===== tb/mfp_pin_model.sv
// Purpose: multi-function pin capacitor seen by the extended blanking counter
// Assumes: one level step per clock stands in for the rc ramp
// Notes: pin holds its level while neither switch is closed
`timescale 1ns/1ps
`default_nettype none
module mfp_pin_model (
  // clock
  input wire logic clk_in,
  // switches from the device
  input wire logic charge_in,
  input wire logic discharge_in,
  // comparator levels back to the device
  output logic below_0v9_out,
  output logic above_4v5_out
);
  int level = 6;
  // ****************************************
  // pin ramp
  // ****************************************
  // discharge wins so a stuck charge switch cannot mask a discharge request
  always @(posedge clk_in) begin
    if (discharge_in && level > 0) begin
      level <= level - 1;
    end else if (charge_in && level < 6) begin
      level <= level + 1;
    end
  end
  assign below_0v9_out = (level <= 1);
  assign above_4v5_out = (level >= 5);
endmodule : mfp_pin_model
`default_nettype wire

// ===== tb/smps_protection_restart_ctrl_props.sv
// Purpose: port assertions of the protection sequencer
// Assumes: single clock domain, srst_in synchronous active high
// Notes: trip checks fire only while switching in run mode
`timescale 1ns/1ps
`default_nettype none
module prot_ctrl_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // watched ports
  input wire prot_pkg::comparators_t cmp_in,
  input wire logic softstart_done_in,
  input wire prot_pkg::stage_ctrl_t ctrl_out,
  input wire prot_pkg::restart_mode_t mode_out,
  input wire logic parity_odd_out,
  input wire logic burst_active_out
);
  logic run;
  logic odd;
  logic non;
  logic live;
  // mode decodes; live excludes the lockout-off cycle where faults are ignored
  assign run = (mode_out == prot_pkg::MODE_RUN);
  assign odd = (mode_out == prot_pkg::MODE_ODD_SKIP);
  assign non = (mode_out == prot_pkg::MODE_NON_SWITCH);
  assign live = run && ctrl_out.gate_enable && !cmp_in.vcc_below_10v5;
  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  a_global_ovp_trip: assert property (live && cmp_in.vcc_above_25v5 && !cmp_in.temp_above_130c
    && !cmp_in.mfp_below_0v4 |=> odd && parity_odd_out) else $error("overvoltage did not trip");
  a_thermal_trip: assert property (live && cmp_in.temp_above_130c |=> non && !ctrl_out.gate_enable)
    else $error("over-temperature did not trip");
  a_ext_enable_trip: assert property (live && cmp_in.mfp_below_0v4 |=> non && !ctrl_out.gate_enable)
    else $error("pin pulldown did not trip");
  a_odd_cycle_silent: assert property (odd && parity_odd_out |-> !ctrl_out.gate_enable)
    else $error("pulses in odd cycle");
  a_nonswitch_silent: assert property (non |-> !ctrl_out.gate_enable) else $error("pulses in non-switch");
  a_lockout_off_restart: assert property (run && ctrl_out.gate_enable && cmp_in.vcc_below_10v5
    |=> mode_out == prot_pkg::MODE_NORMAL_RESTART && ctrl_out.startup_cell_on) else $error("lockout-off ignored");
  a_burst_exit_jump: assert property (burst_active_out && cmp_in.fb_above_4v0
    |=> !burst_active_out && (!run || ctrl_out.full_current_limit)) else $error("burst not left");
  a_burst_entry_held: assert property ($rose(burst_active_out)
    |-> $past(cmp_in.fb_below_burst_entry) && $past(cmp_in.fb_below_burst_entry, 3)) else $error("early burst");
  a_entry_parity_odd: assert property ($rose(odd || non) |-> parity_odd_out) else $error("entry not odd");
  // main scenarios reached
  c_odd_skip: cover property (odd && parity_odd_out);
  c_non_switch: cover property (non);
  c_burst: cover property ($rose(burst_active_out));
endmodule : prot_ctrl_props
bind smps_protection_restart_ctrl prot_ctrl_props chk_u (.clk_in(clk_in), .srst_in(srst_in), .cmp_in(cmp_in),
  .softstart_done_in(softstart_done_in), .ctrl_out(ctrl_out), .mode_out(mode_out),
  .parity_odd_out(parity_odd_out), .burst_active_out(burst_active_out));
`default_nettype wire

// ===== tb/tb_smps_protection_restart_ctrl.sv
// Purpose: self-checking bench of the protection sequencer
// Assumes: shortened timers; comparator bits packed fb first, pin last
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_smps_protection_restart_ctrl;
  localparam int BLANK = 20;
  localparam int SPIKE = 3;
  localparam int EXT = 4;
  typedef struct {
    logic [13:0] fault;
    prot_pkg::restart_mode_t exp;
    logic ss_done;
  } fault_row_t;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ss_in = 1'b0;
  logic pin_low;
  logic pin_high;
  logic prev;
  prot_pkg::comparators_t cmp_tb = 14'h0080;
  prot_pkg::comparators_t cmp_dut;
  prot_pkg::stage_ctrl_t ctrl_out;
  prot_pkg::restart_mode_t mode_out;
  logic parity_odd_out;
  logic burst_active_out;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  int charges;
  int first_dis;
  // overvoltage, softstart overvoltage, thermal, pin pulldown
  fault_row_t rows [4] = '{'{14'h0020, prot_pkg::MODE_ODD_SKIP, 1'b1}, '{14'h3840, prot_pkg::MODE_ODD_SKIP, 1'b0},
    '{14'h0010, prot_pkg::MODE_NON_SWITCH, 1'b1}, '{14'h0004, prot_pkg::MODE_NON_SWITCH, 1'b1}};
  always #5 clk_in = ~clk_in;
  // pin 0.9V and 4.5V comparators come from the model, the rest from the bench
  always_comb begin
    cmp_dut = cmp_tb;
    cmp_dut.mfp_below_0v9 = pin_low;
    cmp_dut.mfp_above_4v5 = pin_high;
  end
  smps_protection_restart_ctrl #(.BLANK_CYCLES(BLANK), .BURST_CYCLES(20), .SPIKE_CYCLES(SPIKE),
    .EXT_COUNT_FULL(EXT)) dut_u (.clk_in(clk_in), .srst_in(srst_in), .cmp_in(cmp_dut), .softstart_done_in(ss_in),
    .ctrl_out(ctrl_out), .mode_out(mode_out), .parity_odd_out(parity_odd_out), .burst_active_out(burst_active_out));
  mfp_pin_model pin_u (.clk_in(clk_in), .charge_in(ctrl_out.charge_switch),
    .discharge_in(ctrl_out.discharge_switch), .below_0v9_out(pin_low), .above_4v5_out(pin_high));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // reset, then lockout-on with soft start optionally finished
  task automatic start(input logic ss_done);
    srst_in = 1'b1;
    cmp_tb = 14'h0080;
    tick(4);
    srst_in = 1'b0;
    tick(1);
    cmp_tb.vcc_below_10v5 = 1'b0;
    tick(1);
    cmp_tb.vcc_above_17v = 1'b1;
    tick(2);
    check("softstart on", ctrl_out.softstart_active, 1'b1);
    ss_in = ss_done;
    tick(1);
    ss_in = 1'b0;
    tick(1);
  endtask : start
  // rail sags to lockout-off, then recharges to lockout-on
  task automatic lockout;
    cmp_tb.vcc_above_17v = 1'b0;
    cmp_tb.vcc_below_10v5 = 1'b1;
    tick(2);
    cmp_tb.vcc_below_10v5 = 1'b0;
    tick(1);
    cmp_tb.vcc_above_17v = 1'b1;
    tick(2);
  endtask : lockout
  task automatic restart_test(input logic [13:0] fault, input logic [13:0] recover, input prot_pkg::restart_mode_t exp);
    start(1'b1);
    cmp_tb = prot_pkg::comparators_t'(cmp_tb | fault);
    tick(2);
    lockout();
    check("even mode", mode_out, exp);
    check("even parity", parity_odd_out, 1'b0);
    if (exp == prot_pkg::MODE_NON_SWITCH) check("even gate", ctrl_out.gate_enable, 1'b0);
    cmp_tb = prot_pkg::comparators_t'(cmp_tb & ~fault);
    if (recover != 14'h0000) begin
      lockout();
      lockout();
      check("held mode", mode_out, exp);
      cmp_tb = prot_pkg::comparators_t'(cmp_tb | recover);
    end
    for (n = 0; n < 4 && mode_out !== prot_pkg::MODE_RUN; n++) lockout();
    check("exit mode", mode_out, prot_pkg::MODE_RUN);
    check("exit parity", parity_odd_out, 1'b0);
    if (mode_out !== prot_pkg::MODE_RUN) test_done();
    $display("restart test done");
  endtask : restart_test
  initial begin
    tick(4);
    srst_in = 1'b0;
    tick(1);
    check("reset mode", mode_out, prot_pkg::MODE_RUN);
    check("reset startup", ctrl_out.startup_cell_on, 1'b1);
    foreach (rows[i]) begin
      start(rows[i].ss_done);
      cmp_tb = prot_pkg::comparators_t'(cmp_tb | rows[i].fault);
      tick(2);
      check("fault mode", mode_out, rows[i].exp);
      check("fault gate", ctrl_out.gate_enable, 1'b0);
      check("fault parity", parity_odd_out, 1'b1);
      $display("fault row %0d done", i);
    end
    restart_test(14'h0020, 14'h0000, prot_pkg::MODE_ODD_SKIP);
    restart_test(14'h0010, 14'h0008, prot_pkg::MODE_NON_SWITCH);
    // overload: feedback pinned high, count charge cycles until the trip
    start(1'b1);
    cmp_tb = prot_pkg::comparators_t'(cmp_tb | 14'h3800);
    charges = 0;
    first_dis = 0;
    prev = 1'b0;
    for (n = 0; n < 300 && mode_out !== prot_pkg::MODE_ODD_SKIP; n++) begin
      tick(1);
      if (ctrl_out.discharge_switch === 1'b1 && first_dis == 0) first_dis = n + 1;
      if (ctrl_out.charge_switch === 1'b1 && prev === 1'b0) charges++;
      prev = ctrl_out.charge_switch;
    end
    check("blank start", first_dis >= BLANK && first_dis <= BLANK + 3, 1'b1);
    check("charges", charges, EXT);
    check("trip time", n >= BLANK + SPIKE, 1'b1);
    check("overload mode", mode_out, prot_pkg::MODE_ODD_SKIP);
    $display("overload test done");
    // burst entry, bias swing, exit on load jump, then undervoltage
    start(1'b1);
    cmp_tb = prot_pkg::comparators_t'(cmp_tb | 14'h0600);
    tick(18);
    check("burst early", burst_active_out, 1'b0);
    for (n = 0; n < 6 && burst_active_out !== 1'b1; n++) tick(1);
    check("burst on", burst_active_out, 1'b1);
    cmp_tb = prot_pkg::comparators_t'((cmp_tb & 14'h3BFF) | 14'h0800);
    tick(2);
    check("bias on", {ctrl_out.internal_bias_on, ctrl_out.burst_limit_select}, 2'h3);
    cmp_tb = prot_pkg::comparators_t'((cmp_tb & 14'h37FF) | 14'h0400);
    tick(2);
    check("bias off", ctrl_out.internal_bias_on, 1'b0);
    cmp_tb = prot_pkg::comparators_t'((cmp_tb & 14'h3BFF) | 14'h2800);
    tick(2);
    check("burst exit", {burst_active_out, ctrl_out.full_current_limit}, 2'h1);
    cmp_tb.vcc_above_17v = 1'b0;
    cmp_tb.vcc_below_10v5 = 1'b1;
    tick(2);
    check("uv mode", mode_out, prot_pkg::MODE_NORMAL_RESTART);
    check("uv startup", ctrl_out.startup_cell_on, 1'b1);
    $display("burst test done");
    test_done();
  end
endmodule : tb_smps_protection_restart_ctrl
`default_nettype wire
